// >>> core/motor_cfg_pkg.sv
// Package with offsets, reset values, field layouts and lookup tables of the configuration bank.
package motor_cfg_pkg;
   // Register indices; the byte address on the bus is four times the index.
   localparam logic [9:0] IDX_FAULT2 = 10'h0a2;
   localparam logic [9:0] IDX_PIN = 10'h0a4;
   localparam logic [9:0] IDX_DEV1 = 10'h0a6;
   localparam logic [9:0] IDX_DEV2 = 10'h0a8;
   localparam logic [9:0] IDX_PERI1 = 10'h0aa;
   localparam logic [9:0] IDX_GD1 = 10'h0ac;
   localparam logic [9:0] IDX_GD2 = 10'h0ae;
   localparam logic [9:0] IDX_STAT = 10'h0b0;
   localparam logic [9:0] IDX_MASK = 10'h0b2;
   // Values after reset.
   localparam logic [31:0] RST_FAULT2 = 32'h00000000;
   localparam logic [31:0] RST_PIN = 32'h00000000;
   localparam logic [31:0] RST_DEV1 = 32'h00000000;
   localparam logic [31:0] RST_DEV2 = 32'h00000000;
   localparam logic [31:0] RST_PERI1 = 32'h40000000;
   localparam logic [31:0] RST_GD1 = 32'h10228100;
   localparam logic [31:0] RST_GD2 = 32'h01200000;
   localparam logic [2:0] RST_EVT = 3'h0;
   // Event bit positions in the status and mask registers.
   localparam int ST_LOW = 0;
   localparam int ST_HIGH = 1;
   localparam int ST_RETRY = 2;
   // Supply thresholds in tenths of a volt, indexed by the limit code.
   localparam logic [9:0] LOW_LIMIT_DV [8] = '{10'h000, 10'h02d, 10'h032, 10'h037,
                                              10'h03c, 10'h04b, 10'h064, 10'h07d};
   localparam logic [9:0] HIGH_LIMIT_DV [8] = '{10'h000, 10'h0c8, 10'h0e1, 10'h0fa,
                                               10'h113, 10'h12c, 10'h145, 10'h15e};
   // Retry attempts allowed, indexed by the retry code; zero means unlimited.
   localparam logic [4:0] RETRY_LIMIT [8] = '{5'h00, 5'h02, 5'h03, 5'h05,
                                             5'h07, 5'h0a, 5'h0f, 5'h14};
   // Speed feedback and brake override codes.
   localparam logic [1:0] FB_FOLLOW = 2'h0;
   localparam logic [1:0] FB_HIGH = 2'h1;
   localparam logic [1:0] FB_LOW = 2'h2;
   localparam logic [1:0] FB_BEMF = 2'h3;
   localparam logic [1:0] BRK_FORCE = 2'h1;
   localparam logic [1:0] BRK_NONE = 2'h2;
   // Layout of the supply fault setup register.
   typedef struct packed {
      logic [20:0] rsvd;
      logic [2:0] low_supply_run_limit;
      logic low_supply_recovery_select;
      logic [2:0] high_supply_run_limit;
      logic high_supply_recovery_select;
      logic [2:0] retry_count_limit;
   } fault_setup_t;
   // Layout of the pin function setup register.
   typedef struct packed {
      logic [3:0] rsvd_hi;
      logic supply_filter_bypass;
      logic [15:0] rsvd_mid;
      logic [1:0] speed_feedback_stop_behaviour;
      logic [1:0] speed_feedback_fault_behaviour;
      logic alarm_enable;
      logic brake_align_mode;
      logic preset_angle_select;
      logic [1:0] brake_override;
      logic [1:0] speed_input_mode;
   } pin_setup_t;
endpackage : motor_cfg_pkg

// >>> core/motor_fault_pin_config_regs.sv
// Configuration bank for supply limits, retries, speed feedback, alarm and brake control.
`timescale 1ns/1ns
module motor_fault_pin_config_regs
   import motor_cfg_pkg::*;
#(
   parameter int FILT_SHIFT = 2
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [9:0] supply_sample,
   input wire logic motor_stopped,
   input wire logic fault_active,
   input wire logic retry_attempt,
   input wire logic fb_drive,
   input wire logic bemf_below_threshold,
   input wire logic speed_feedback_coast_setting,
   input wire logic brake_pin,
   output logic run_block,
   output logic low_supply_fault,
   output logic high_supply_fault,
   output logic retry_exhausted,
   output logic speed_feedback_output,
   output logic alarm_pin,
   output logic brake_active,
   output logic align_brake,
   output logic use_preset_angle,
   output logic [9:0] supply_filtered,
   output logic irq
);
   localparam int AW = 10 + FILT_SHIFT;

   // Refuse filter depths the accumulator cannot hold.
   if (FILT_SHIFT < 1 || FILT_SHIFT > 6) begin : g_bad_shift
      $error("FILT_SHIFT must lie between 1 and 6");
   end

   fault_setup_t fault_setup;
   pin_setup_t pin_setup;
   logic [31:0] dev_one, dev_two, peri_one, gd_one, gd_two;
   logic [2:0] status, mask;
   logic [AW-1:0] acc;
   logic [4:0] retry_cnt;
   logic last_fb, brk_meta, brk_sync;
   fault_setup_t next_fault_setup;
   pin_setup_t next_pin_setup;
   logic [31:0] next_dev_one, next_dev_two, next_peri_one, next_gd_one, next_gd_two;
   logic [31:0] next_prdata;
   logic [2:0] next_status, next_mask, events, clr;
   logic next_pready, next_pslverr, next_irq;
   logic [AW-1:0] next_acc;
   logic [9:0] next_filtered, volt;
   logic [4:0] next_retry_cnt, lim;
   logic next_low, next_high, next_exh, low_cond, high_cond;
   logic next_fb, next_last_fb, next_brake, next_align, next_preset, next_alarm;
   logic done, wr, hit;
   logic [9:0] idx;

   // Maps a register index onto whether it exists.
   function automatic logic mapped(input logic [9:0] i);
      mapped = (i == IDX_FAULT2) || (i == IDX_PIN) || (i == IDX_DEV1) || (i == IDX_DEV2)
            || (i == IDX_PERI1) || (i == IDX_GD1) || (i == IDX_GD2)
            || (i == IDX_STAT) || (i == IDX_MASK);
   endfunction : mapped

   assign idx = paddr[11:2];
   assign done = psel && penable && pready;
   assign wr = done && pwrite;
   assign hit = mapped(idx);
   assign clr = (wr && idx == IDX_STAT) ? pwdata[2:0] : 3'h0;

   // Bus slave: one wait state, then the write lands and read data is presented.
   always_comb
   begin
      next_fault_setup = fault_setup;
      next_pin_setup = pin_setup;
      next_dev_one = dev_one;
      next_dev_two = dev_two;
      next_peri_one = peri_one;
      next_gd_one = gd_one;
      next_gd_two = gd_two;
      next_mask = mask;
      next_pready = psel && penable && !pready;
      next_pslverr = psel && penable && !pready && !hit;
      next_prdata = 32'h00000000;
      if (psel && penable && !pready && !pwrite)
      begin
         unique case (idx)
            IDX_FAULT2: next_prdata = fault_setup;
            IDX_PIN: next_prdata = pin_setup;
            IDX_DEV1: next_prdata = dev_one;
            IDX_DEV2: next_prdata = dev_two;
            IDX_PERI1: next_prdata = peri_one;
            IDX_GD1: next_prdata = gd_one;
            IDX_GD2: next_prdata = gd_two;
            IDX_STAT: next_prdata = {29'h00000000, status};
            IDX_MASK: next_prdata = {29'h00000000, mask};
            default: next_prdata = 32'h00000000;
         endcase
      end
      if (wr)
      begin
         unique case (idx)
            IDX_FAULT2: next_fault_setup = pwdata;
            IDX_PIN: next_pin_setup = pwdata;
            IDX_DEV1: next_dev_one = pwdata;
            IDX_DEV2: next_dev_two = pwdata;
            IDX_PERI1: next_peri_one = pwdata;
            IDX_GD1: next_gd_one = pwdata;
            IDX_GD2: next_gd_two = pwdata;
            IDX_MASK: next_mask = pwdata[2:0];
            default: next_mask = mask;
         endcase
      end
   end

   // Registers the bus side and the stored setup words.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fault_setup <= RST_FAULT2;
         pin_setup <= RST_PIN;
         dev_one <= RST_DEV1;
         dev_two <= RST_DEV2;
         peri_one <= RST_PERI1;
         gd_one <= RST_GD1;
         gd_two <= RST_GD2;
         mask <= RST_EVT;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else
      begin
         fault_setup <= next_fault_setup;
         pin_setup <= next_pin_setup;
         dev_one <= next_dev_one;
         dev_two <= next_dev_two;
         peri_one <= next_peri_one;
         gd_one <= next_gd_one;
         gd_two <= next_gd_two;
         mask <= next_mask;
         pready <= next_pready;
         pslverr <= next_pslverr;
         prdata <= next_prdata;
      end
   end

   // Supply filter, limit checks, fault recovery, retry count and event flags.
   always_comb
   begin
      next_acc = AW'(acc - (acc >> FILT_SHIFT) + {{FILT_SHIFT{1'b0}}, supply_sample});
      next_filtered = pin_setup.supply_filter_bypass ? supply_sample
                                                      : 10'(acc >> FILT_SHIFT);
      volt = supply_filtered;
      low_cond = (fault_setup.low_supply_run_limit != 3'h0)
               && (volt < LOW_LIMIT_DV[fault_setup.low_supply_run_limit]);
      high_cond = (fault_setup.high_supply_run_limit != 3'h0)
                && (volt > HIGH_LIMIT_DV[fault_setup.high_supply_run_limit]);
      next_low = low_cond || (low_supply_fault && !fault_setup.low_supply_recovery_select
                              && !clr[ST_LOW]);
      next_high = high_cond || (high_supply_fault && !fault_setup.high_supply_recovery_select
                                && !clr[ST_HIGH]);
      lim = RETRY_LIMIT[fault_setup.retry_count_limit];
      next_retry_cnt = retry_cnt;
      if (!fault_active)
      begin
         next_retry_cnt = 5'h00;
      end
      else if (retry_attempt && !retry_exhausted && retry_cnt != 5'h1f)
      begin
         next_retry_cnt = 5'(retry_cnt + 5'h01);
      end
      next_exh = (lim != 5'h00) && (next_retry_cnt >= lim);
      events = {next_exh && !retry_exhausted, next_high && !high_supply_fault,
                next_low && !low_supply_fault};
      next_status = (status & ~clr) | events;
      next_irq = |(next_status & mask);
   end

   // Registers the supply and fault state.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         acc <= '0;
         supply_filtered <= 10'h000;
         low_supply_fault <= 1'b0;
         high_supply_fault <= 1'b0;
         run_block <= 1'b0;
         retry_cnt <= 5'h00;
         retry_exhausted <= 1'b0;
         status <= RST_EVT;
         irq <= 1'b0;
      end
      else
      begin
         acc <= next_acc;
         supply_filtered <= next_filtered;
         low_supply_fault <= next_low;
         high_supply_fault <= next_high;
         run_block <= next_low || next_high;
         retry_cnt <= next_retry_cnt;
         retry_exhausted <= next_exh;
         status <= next_status;
         irq <= next_irq;
      end
   end

   // Speed feedback, alarm and brake outputs.
   always_comb
   begin
      next_last_fb = last_fb;
      next_fb = fb_drive;
      if (fault_active)
      begin
         unique case (pin_setup.speed_feedback_fault_behaviour)
            FB_FOLLOW: next_fb = last_fb;
            FB_HIGH: next_fb = 1'b1;
            FB_LOW: next_fb = 1'b0;
            FB_BEMF: next_fb = (speed_feedback_coast_setting && !bemf_below_threshold)
                               ? fb_drive : last_fb;
         endcase
      end
      else if (motor_stopped)
      begin
         unique case (pin_setup.speed_feedback_stop_behaviour)
            FB_FOLLOW: next_fb = fb_drive;
            FB_LOW: next_fb = 1'b0;
            default: next_fb = 1'b1;
         endcase
      end
      else
      begin
         next_last_fb = fb_drive;
      end
      unique case (pin_setup.brake_override)
         BRK_FORCE: next_brake = 1'b1;
         BRK_NONE: next_brake = 1'b0;
         default: next_brake = brk_sync;
      endcase
      next_align = next_brake && pin_setup.brake_align_mode;
      next_preset = next_align && pin_setup.preset_angle_select;
      next_alarm = pin_setup.alarm_enable
                 && (fault_active || low_supply_fault || high_supply_fault);
   end

   // Registers the pin outputs and synchronises the brake pin.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         brk_meta <= 1'b0;
         brk_sync <= 1'b0;
         last_fb <= 1'b0;
         speed_feedback_output <= 1'b0;
         brake_active <= 1'b0;
         align_brake <= 1'b0;
         use_preset_angle <= 1'b0;
         alarm_pin <= 1'b0;
      end
      else
      begin
         brk_meta <= brake_pin;
         brk_sync <= brk_meta;
         last_fb <= next_last_fb;
         speed_feedback_output <= next_fb;
         brake_active <= next_brake;
         align_brake <= next_align;
         use_preset_angle <= next_preset;
         alarm_pin <= next_alarm;
      end
   end

   // Checks on the documented behaviour.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_low_set: assert property (low_cond |=> low_supply_fault && run_block)
      else $error("low supply fault not raised");
   chk_low_latch: assert property (low_supply_fault && !fault_setup.low_supply_recovery_select
      && !clr[ST_LOW] |=> low_supply_fault)
      else $error("latched low supply fault dropped");
   chk_high_set: assert property (high_cond |=> high_supply_fault && run_block)
      else $error("high supply fault not raised");
   chk_high_auto: assert property (fault_setup.high_supply_recovery_select && !high_cond
      |=> !high_supply_fault)
      else $error("high supply fault did not clear itself");
   chk_retry_stop: assert property (fault_active && lim != 5'h00 && retry_cnt >= lim
      && $stable(lim) |-> retry_exhausted)
      else $error("retry limit not flagged");
   chk_filter_bypass: assert property (pin_setup.supply_filter_bypass
      |=> supply_filtered == $past(supply_sample))
      else $error("filter bypass ignored");
   chk_fb_stop: assert property (!fault_active && motor_stopped
      && pin_setup.speed_feedback_stop_behaviour == FB_LOW |=> !speed_feedback_output)
      else $error("stop feedback not low");
   chk_fb_fault: assert property (fault_active
      && pin_setup.speed_feedback_fault_behaviour == FB_HIGH |=> speed_feedback_output)
      else $error("fault feedback not high");
   chk_alarm_gate: assert property (!pin_setup.alarm_enable |=> !alarm_pin)
      else $error("alarm active while disabled");
   chk_brake_mode: assert property (brake_active |-> align_brake
      == $past(pin_setup.brake_align_mode))
      else $error("brake mode mismatch");
   chk_brake_none: assert property (pin_setup.brake_override == BRK_NONE
      |=> !brake_active && !align_brake)
      else $error("brake active despite override");
   chk_unmapped_err: assert property (psel && penable && !pready && !hit
      |=> pready && pslverr && prdata == 32'h00000000)
      else $error("unmapped access not refused");

   cov_low_fault: cover property (!low_supply_fault ##1 low_supply_fault);
   cov_retry_end: cover property (fault_active && retry_exhausted);
   cov_align: cover property (use_preset_angle);
   cov_irq: cover property (!irq ##1 irq);
endmodule : motor_fault_pin_config_regs

// >>> testbench/apb_host_model.sv
// Host model that performs APB register transfers towards the configuration bank.
`timescale 1ns/1ns
module apb_host_model
(
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // Bus is idle from time zero until the first transfer.
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
   end

   // One transfer: setup cycle, access phase held until pready is seen at an edge.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e, output logic ok);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      ok = (pready === 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   // Updates chosen bits only, so reserved bits keep what they hold.
   task automatic rmw(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
      logic [31:0] q;
      logic e;
      logic ok;
      xfer(1'b0, a, 32'h00000000, q, e, ok);
      xfer(1'b1, a, (q & ~m) | (v & m), q, e, ok);
   endtask : rmw
endmodule : apb_host_model

// >>> testbench/motor_fault_pin_config_regs_tb.sv
// Self-checking testbench for the motor fault and pin configuration bank.
`timescale 1ns/1ns
module motor_fault_pin_config_regs_tb
   import motor_cfg_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [9:0] supply_sample = 10'h064;
   logic motor_stopped = 1'b0;
   logic fault_active = 1'b0;
   logic retry_attempt = 1'b0;
   logic fb_drive = 1'b0;
   logic bemf_below_threshold = 1'b0;
   logic speed_feedback_coast_setting = 1'b1;
   logic brake_pin = 1'b0;
   logic run_block, low_supply_fault, high_supply_fault, retry_exhausted;
   logic speed_feedback_output, alarm_pin, brake_active, align_brake, use_preset_angle, irq;
   logic [9:0] supply_filtered;
   int bad_count = 0;
   int compares = 0;
   pin_setup_t p;
   localparam logic [11:0] A_FLT = {IDX_FAULT2, 2'b00};
   localparam logic [11:0] A_PIN = {IDX_PIN, 2'b00};
   localparam logic [11:0] A_ST = {IDX_STAT, 2'b00};
   localparam logic [11:0] A_MK = {IDX_MASK, 2'b00};
   localparam logic [11:0] AMAP [9] = '{A_FLT, A_PIN, {IDX_DEV1, 2'b00}, {IDX_DEV2, 2'b00},
      {IDX_PERI1, 2'b00}, {IDX_GD1, 2'b00}, {IDX_GD2, 2'b00}, A_ST, A_MK};
   localparam logic [31:0] RMAP [9] = '{RST_FAULT2, RST_PIN, RST_DEV1, RST_DEV2, RST_PERI1,
      RST_GD1, RST_GD2, 32'h00000000, 32'h00000000};

   // Clock of 100 ns period.
   always #50 pclk = ~pclk;

   motor_fault_pin_config_regs motor_fault_pin_config_regs_inst (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .supply_sample(supply_sample), .motor_stopped(motor_stopped),
      .fault_active(fault_active), .retry_attempt(retry_attempt), .fb_drive(fb_drive),
      .bemf_below_threshold(bemf_below_threshold),
      .speed_feedback_coast_setting(speed_feedback_coast_setting), .brake_pin(brake_pin),
      .run_block(run_block), .low_supply_fault(low_supply_fault),
      .high_supply_fault(high_supply_fault), .retry_exhausted(retry_exhausted),
      .speed_feedback_output(speed_feedback_output), .alarm_pin(alarm_pin),
      .brake_active(brake_active), .align_brake(align_brake),
      .use_preset_angle(use_preset_angle), .supply_filtered(supply_filtered), .irq(irq));

   apb_host_model apb_host_model_inst (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   // Compares a seen value with the expected one and counts the result.
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      compares++;
      if (s !== x)
      begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, x);
      end
   endtask : chk

   // Register write and checked register read with their slave error answers.
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic xe = 1'b0);
      logic [31:0] q;
      logic e;
      logic ok;
      apb_host_model_inst.xfer(1'b1, a, d, q, e, ok);
      chk({e, ok}, {xe, 1'b1});
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe = 1'b0);
      logic [31:0] q;
      logic e;
      logic ok;
      apb_host_model_inst.xfer(1'b0, a, 32'h00000000, q, e, ok);
      chk({e, ok}, {xe, 1'b1});
      chk(q, x);
   endtask : rd

   task automatic settle(input int n = 5);
      repeat (n) @(posedge pclk);
   endtask : settle

   task automatic pulse;
      @(posedge pclk);
      retry_attempt <= 1'b1;
      @(posedge pclk);
      retry_attempt <= 1'b0;
   endtask : pulse

   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : finish_test

   // Watchdog against a hung transfer or sequence.
   initial
   begin
      #1500000;
      bad_count++;
      finish_test();
   end

   // Main sequence of tests.
   initial
   begin
      settle(3);
      presetn <= 1'b1;
      for (int i = 0; i < 9; i++)
         rd(AMAP[i], RMAP[i]);
      rd(12'h000, 32'h00000000, 1'b1);
      wr(12'h000, 32'hffffffff, 1'b1);
      rd(12'h000, 32'h00000000, 1'b1);
      for (int i = 0; i < 7; i++)
      begin
         wr(AMAP[i], ~RMAP[i]);
         rd(AMAP[i], ~RMAP[i]);
         wr(AMAP[i], RMAP[i]);
      end
      $display("test registers done");
      settle(40);
      chk(supply_filtered, 10'h064);
      supply_sample <= 10'h0c8;
      settle(2);
      chk(supply_filtered == 10'h0c8, 1'b0);
      apb_host_model_inst.rmw(A_PIN, 32'h08000000, 32'h08000000);
      supply_sample <= 10'h0f0;
      settle(2);
      chk(supply_filtered, 10'h0f0);
      $display("test filter done");
      for (int c = 1; c < 8; c++)
      begin
         wr(A_FLT, {21'h0, c[2:0], 1'b1, 7'h00});
         supply_sample <= LOW_LIMIT_DV[c] - 10'h001;
         settle();
         chk({low_supply_fault, run_block}, 2'b11);
         supply_sample <= LOW_LIMIT_DV[c];
         settle();
         chk({low_supply_fault, run_block}, 2'b00);
         wr(A_FLT, {25'h0, c[2:0], 1'b1, 3'h0});
         supply_sample <= HIGH_LIMIT_DV[c] + 10'h001;
         settle();
         chk({high_supply_fault, run_block}, 2'b11);
         supply_sample <= HIGH_LIMIT_DV[c];
         settle();
         chk({high_supply_fault, run_block}, 2'b00);
      end
      wr(A_ST, 32'h00000007);
      wr(A_MK, 32'h00000000);
      wr(A_FLT, 32'h00000170);
      supply_sample <= 10'h02c;
      settle();
      supply_sample <= 10'h0f0;
      settle();
      chk({low_supply_fault, irq}, 2'b10);
      rd(A_ST, 32'h00000001);
      wr(A_MK, 32'h00000003);
      settle(2);
      chk(irq, 1'b1);
      wr(A_ST, 32'h00000001);
      settle();
      chk({low_supply_fault, irq}, 2'b00);
      supply_sample <= 10'h15f;
      settle();
      supply_sample <= 10'h0f0;
      settle();
      chk({high_supply_fault, run_block, irq}, 3'b111);
      wr(A_ST, 32'h00000002);
      settle();
      chk({high_supply_fault, irq}, 2'b00);
      $display("test supply done");
      wr(A_MK, 32'h00000004);
      for (int c = 0; c < 8; c++)
      begin
         wr(A_FLT, {29'h0, c[2:0]});
         fault_active <= 1'b1;
         repeat ((c == 0) ? 24 : RETRY_LIMIT[c] - 1) pulse();
         settle(3);
         chk(retry_exhausted, 1'b0);
         pulse();
         settle(3);
         chk(retry_exhausted, c != 0);
         fault_active <= 1'b0;
         settle(3);
         chk(retry_exhausted, 1'b0);
      end
      rd(A_ST, 32'h00000004);
      chk(irq, 1'b1);
      wr(A_ST, 32'h00000004);
      $display("test retry done");
      p = '0;
      motor_stopped <= 1'b1;
      for (int f = 0; f < 2; f++)
         for (int c = 0; c < 4; c++)
         begin
            p.speed_feedback_stop_behaviour = c[1:0];
            wr(A_PIN, p);
            fb_drive <= f[0];
            settle();
            chk(speed_feedback_output, (c == 0) ? f[0] : (c != 2));
         end
      motor_stopped <= 1'b0;
      fb_drive <= 1'b1;
      settle();
      fault_active <= 1'b1;
      fb_drive <= 1'b0;
      for (int c = 0; c < 4; c++)
      begin
         p.speed_feedback_fault_behaviour = c[1:0];
         wr(A_PIN, p);
         settle();
         chk(speed_feedback_output, c < 2);
      end
      fb_drive <= 1'b1;
      settle();
      chk(speed_feedback_output, 1'b1);
      bemf_below_threshold <= 1'b1;
      fb_drive <= 1'b0;
      settle();
      chk(speed_feedback_output, 1'b1);
      bemf_below_threshold <= 1'b0;
      speed_feedback_coast_setting <= 1'b0;
      settle();
      chk(speed_feedback_output, 1'b1);
      chk(alarm_pin, 1'b0);
      p.alarm_enable = 1'b1;
      wr(A_PIN, p);
      settle();
      chk(alarm_pin, 1'b1);
      fault_active <= 1'b0;
      $display("test feedback done");
      brake_pin <= 1'b1;
      settle();
      chk({brake_active, align_brake, use_preset_angle}, 3'b100);
      p.brake_align_mode = 1'b1;
      wr(A_PIN, p);
      settle();
      chk({brake_active, align_brake, use_preset_angle}, 3'b110);
      p.preset_angle_select = 1'b1;
      wr(A_PIN, p);
      settle();
      chk({brake_active, align_brake, use_preset_angle}, 3'b111);
      for (int c = 0; c < 8; c++)
      begin
         p.brake_override = c[1:0];
         wr(A_PIN, p);
         brake_pin <= c[2];
         settle();
         chk(brake_active, (c[1:0] == BRK_FORCE) || (c[1:0] != BRK_NONE && c[2]));
      end
      $display("test brake done");
      finish_test();
   end
endmodule : motor_fault_pin_config_regs_tb
